// File: bench/sal_tb.sv
// Purpose: Self-checking bench for the analog loop configuration block
// Assumes: Wishbone answers one cycle after a request is taken
// Notes: Seeded random boot sources and divider writes, with corner values
`timescale 1ns/10ps
`include "sal_consts.svh"
module testbench;
  import sal_pkg::*;
  logic clock, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, loop_dbl, gpio_status;
  logic [7:0] wb_adr_i, vctrl;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, lo, hi;
  logic otp_en, otp_valid, otp_dbl, eep_en, eep_valid, eep_dbl, edbl, b;
  logic [9:0] otp_div, eep_div, loop_div, ediv, d;
  logic [12:0] e;
  logic [1:0] esrc;
  int failures, cmp_count, cyc_cnt;

  sal_system_analog_loop_ctrl dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .otp_en(otp_en), .otp_valid(otp_valid),
    .otp_div(otp_div), .otp_dbl(otp_dbl), .eep_en(eep_en), .eep_valid(eep_valid),
    .eep_div(eep_div), .eep_dbl(eep_dbl), .vctrl(vctrl), .loop_div(loop_div),
    .loop_dbl(loop_dbl), .gpio_status(gpio_status));

  // Free-running 20 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clock)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // One classic cycle; entered just after a rising edge, data taken in the ack cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s,
                    output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= dt;
    wb_sel_i <= s;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      chk("ack", 32'h1, 32'h0);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask : wb

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask : do_reset

  // Boot outcome: {source, doubler, divider}; an out-of-range divider disqualifies a source
  function automatic logic [12:0] boot_exp();
    if (otp_en && otp_valid && otp_div >= `SAL_DIV_MIN && otp_div <= `SAL_DIV_MAX)
      return {2'h1, otp_dbl, otp_div};
    if (eep_en && eep_valid && eep_div >= `SAL_DIV_MIN && eep_div <= `SAL_DIV_MAX)
      return {2'h2, eep_dbl, eep_div};
    return {2'h0, `SAL_DBL_RST, `SAL_DIV_RST};
  endfunction : boot_exp

  function automatic logic [7:0] centre(input logic [9:0] dv, input logic db);
    return 8'h80 + {2'h0, dv[9:4]} - {7'h0, db};
  endfunction : centre

  initial
  begin
    void'($urandom(94373));
    {wb_cyc_i, wb_stb_i, wb_we_i, otp_en, otp_valid, otp_dbl, eep_en, eep_valid, eep_dbl} <= 9'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} <= 44'h0;
    {otp_div, eep_div} <= 20'h0;
    vctrl <= 8'h00;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    // Boot from random sources; first pass has none, second has all
    for (int i = 0; i < 16; i++)
    begin
      {otp_en, otp_valid, eep_en, eep_valid} <= (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
      otp_div <= 10'(100 + $urandom % 480);
      eep_div <= 10'(100 + $urandom % 480);
      {otp_dbl, eep_dbl} <= 2'($urandom);
      do_reset();
      e = boot_exp();
      chk("boot div", 32'(e[9:0]), 32'(loop_div));
      chk("boot dbl", 32'(e[10]), 32'(loop_dbl));
      wb(1'b0, `SAL_OFF_STAT, 32'h0, 4'hf, q);
      // Boot done and, with the voltage parked at zero, the alarm live
      chk("boot src", {28'h0, e[12:11], 2'h3}, {28'h0, q[5:4], q[2:1]});
      wb(1'b0, `SAL_OFF_NVM, 32'h0, 4'hf, q);
      chk("nvm", {28'h0, eep_valid, eep_en, otp_valid, otp_en}, q);
    end
    {otp_en, eep_en} <= 2'h0;
    do_reset();
    ediv = `SAL_DIV_RST;
    edbl = 1'b0;
    esrc = 2'h0;
    // Divider writes: limits, just outside them, a partial-lane write, then random
    for (int j = 0; j < 10; j++)
    begin
      d = (j == 0) ? 10'd121 : (j == 1) ? 10'd122 : (j == 2) ? 10'd560 : (j == 3) ? 10'd561
        : 10'(`SAL_DIV_MIN + $urandom % 439);
      b = 1'($urandom);
      wb(1'b1, `SAL_OFF_CFG, {15'h0, b, 6'h0, d}, (j == 4) ? 4'h1 : 4'hf, q);
      // Doubler lane is taken on its own even when the divider is refused
      if (j != 4)
      begin
        edbl = b;
        esrc = 2'h3;
      end
      if (j != 0 && j != 3 && j != 4)
      begin
        ediv = d;
      end
      chk("cfg div", 32'(ediv), 32'(loop_div));
      chk("cfg dbl", 32'(edbl), 32'(loop_dbl));
      wb(1'b0, `SAL_OFF_CFG, 32'h0, 4'hf, q);
      chk("cfg read", {15'h0, edbl, 6'h0, ediv}, {15'h0, q[16], 6'h0, q[9:0]});
      wb(1'b0, `SAL_OFF_STAT, 32'h0, 4'hf, q);
      chk("src", 32'(esrc), 32'(q[5:4]));
    end
    // Frequency ratio words round-trip all 64 bits
    lo = $urandom;
    hi = $urandom;
    wb(1'b1, `SAL_OFF_FREQ_LO, lo, 4'hf, q);
    wb(1'b1, `SAL_OFF_FREQ_HI, hi, 4'hf, q);
    wb(1'b0, `SAL_OFF_FREQ_LO, 32'h0, 4'hf, q);
    chk("freq num lo", lo, q);
    wb(1'b0, `SAL_OFF_FREQ_HI, 32'h0, 4'hf, q);
    chk("freq den num hi", hi, q);
    // Unmapped place reads zero
    wb(1'b1, 8'h20, 32'hffffffff, 4'hf, q);
    wb(1'b0, 8'h20, 32'h0, 4'hf, q);
    chk("unmapped", 32'h0, q);
    // Lock needs the qualifying time inside the derived window
    wb(1'b1, `SAL_OFF_GPIO, 32'h1, 4'hf, q);
    vctrl <= centre(ediv, edbl);
    repeat (8) @(posedge clock);
    chk("early alarm", 32'h1, 32'(gpio_status));
    wb(1'b0, `SAL_OFF_STAT, 32'h0, 4'hf, q);
    chk("not yet", 32'h2, 32'(q[1:0]));
    repeat (20) @(posedge clock);
    wb(1'b0, `SAL_OFF_STAT, 32'h0, 4'hf, q);
    chk("locked", 32'h1, 32'(q[1:0]));
    chk("pin quiet", 32'h0, 32'(gpio_status));
    vctrl <= centre(ediv, edbl) + `SAL_LOCK_MARGIN + 8'h01;
    repeat (4) @(posedge clock);
    wb(1'b0, `SAL_OFF_STAT, 32'h0, 4'hf, q);
    chk("lost", 32'h2, 32'(q[1:0]));
    chk("pin alarm", 32'h1, 32'(gpio_status));
    wb(1'b1, `SAL_OFF_GPIO, 32'h0, 4'hf, q);
    chk("pin unrouted", 32'h0, 32'(gpio_status));
    summarize();
  end
endmodule : testbench

// File: core/sal_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts for the analog loop block
// Assumes: Included by bare name from the design files
// Notes: Register offsets are byte addresses of aligned 32-bit words
`ifndef SAL_CONSTS_SVH
`define SAL_CONSTS_SVH

// Register byte offsets
`define SAL_OFF_CFG 8'h00
`define SAL_OFF_STAT 8'h04
`define SAL_OFF_GPIO 8'h08
`define SAL_OFF_NVM 8'h0c
`define SAL_OFF_FREQ_LO 8'h10
`define SAL_OFF_FREQ_HI 8'h14

// Configuration field positions
`define SAL_CFG_DIV_LSB 0
`define SAL_CFG_DIV_MSB 9
`define SAL_CFG_DBL_BIT 16

// Status field positions
`define SAL_ST_LOCK_BIT 0
`define SAL_ST_LOL_BIT 1
`define SAL_ST_BOOT_BIT 2
`define SAL_ST_SRC_LSB 4

// Divider limits and hardware defaults
`define SAL_DIV_MIN 10'd122
`define SAL_DIV_MAX 10'd560
`define SAL_DIV_RST 10'd280
`define SAL_DBL_RST 1'b0

// Voltage window spread in control code steps
`define SAL_LOCK_MARGIN 8'h20

// Lock qualification: time in ns, cycles at 50 ns period (least time, rounded up)
`define SAL_CLK_NS 50
`define SAL_LOCK_QUAL_NS 1000
`define SAL_LOCK_QUAL_CYC ((`SAL_LOCK_QUAL_NS + `SAL_CLK_NS - 1) / `SAL_CLK_NS)

`endif

// File: core/sal_freq_mem.sv
// Purpose: Small store of frequency ratio words for the analog loop block
// Assumes: One write port, one read port, synchronous read
// Notes: Read data always comes from a register
`timescale 1ns/10ps
module sal_freq_mem
  import sal_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int WIDTH = 32
)
(
  input wire logic clock,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  initial
  begin
    if (DEPTH < 2 || WIDTH < 1)
    begin
      $error("sal_freq_mem: bad geometry");
    end
  end

  logic [WIDTH-1:0] mem_r [DEPTH];

  // Memory content has no reset; software loads it before use
  always_ff @(posedge clock)
  begin
    if (we)
    begin
      mem_r[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clock)
  begin
    rdata <= mem_r[raddr];
  end

endmodule : sal_freq_mem

// File: core/sal_lock_det.sv
// Purpose: Lock detector comparing control voltage code to a derived window
// Assumes: Control voltage arrives as a digital code synchronous to clock
// Notes: Window follows the divider and doubler, never programmed by software
`timescale 1ns/10ps
`include "sal_consts.svh"
module sal_lock_det
  import sal_pkg::*;
#(
  parameter int VC_W = 8,
  parameter int QUAL = `SAL_LOCK_QUAL_CYC
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [VC_W-1:0] vctrl,
  input wire logic [9:0] div,
  input wire logic dbl,
  input wire logic cfg_chg,
  output logic locked
);

  initial
  begin
    if (VC_W < 8 || QUAL < 1 || QUAL > 65535)
    begin
      $error("sal_lock_det: bad parameters");
    end
  end

  // Centre of the window shifts with the loop setting
  function automatic logic [VC_W-1:0] win_ctr(input logic [9:0] d, input logic db);
    logic [VC_W-1:0] base;
    base = VC_W'(8'h80);
    win_ctr = base + VC_W'(d[9:4]) - VC_W'(db);
  endfunction : win_ctr

  logic [VC_W-1:0] lo_lim;
  logic [VC_W-1:0] hi_lim;
  logic in_win;
  logic [15:0] qual_r;

  // Limits derived internally from the configuration
  assign lo_lim = win_ctr(div, dbl) - VC_W'(`SAL_LOCK_MARGIN); // RULE7
  assign hi_lim = win_ctr(div, dbl) + VC_W'(`SAL_LOCK_MARGIN); // RULE7
  assign in_win = (vctrl >= lo_lim) && (vctrl <= hi_lim);

  // A config change restarts qualification so lock is never claimed across it
  always_ff @(posedge clock)
  begin
    if (!rst_n || cfg_chg || !in_win)
    begin
      qual_r <= 16'h0000;
      locked <= 1'b0;
    end
    else if (qual_r < 16'(QUAL))
    begin
      qual_r <= qual_r + 16'h0001;
    end
    else
    begin
      locked <= 1'b1; // RULE7
    end
  end

  AST_LOCK_NEEDS_WIN: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
    locked |-> $past(in_win))
    else $error("locked while voltage outside window");

endmodule : sal_lock_det

// File: core/sal_pkg.sv
// Purpose: Types shared by the analog loop configuration block
// Assumes: Offsets and counts live in sal_consts.svh
// Notes: Types only
package sal_pkg;

  // Boot loader states
  typedef enum logic [2:0] {
    SAL_BOOT_IDLE = 3'b000,
    SAL_BOOT_OTP = 3'b001,
    SAL_BOOT_EEP = 3'b010,
    SAL_BOOT_DFLT = 3'b011,
    SAL_BOOT_DONE = 3'b100
  } sal_boot_e;

  // Source of the current loop settings
  typedef enum logic [1:0] {
    SAL_SRC_DFLT = 2'b00,
    SAL_SRC_OTP = 2'b01,
    SAL_SRC_EEP = 2'b10,
    SAL_SRC_SW = 2'b11
  } sal_src_e;

  typedef logic [47:0] sal_num_t;
  typedef logic [15:0] sal_den_t;

endpackage : sal_pkg

// File: core/sal_system_analog_loop_ctrl.sv
// Purpose: Configuration, boot load and lock alarm for the system analog loop
// Assumes: Classic Wishbone slave, 32-bit data, one wait state on every access
// Notes: Contract
// Contract
// RULE1: Frequencies are 48-bit numerator over 16-bit denominator; the ratio view here ties numerator bits 47:32 to zero
// RULE2: Setting picks crystal direct or doubled reference
// RULE3: Feedback divider accepts integers 122 through 560
// RULE4: Software keeps loop within tuning range
// RULE5: Reset loads fields from enabled valid nonvolatile
// RULE6: After boot software may rewrite configuration anytime
// RULE7: Lock from control voltage within derived limits
// RULE8: Loss-of-lock alarm in status, optional pin
// RULE9: No valid source keeps hardware defaults
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "sal_consts.svh"
module sal_system_analog_loop_ctrl
  import sal_pkg::*;
#(
  parameter int VC_W = 8,
  parameter int FMEM_DEPTH = 4
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic otp_en,
  input wire logic otp_valid,
  input wire logic [9:0] otp_div,
  input wire logic otp_dbl,
  input wire logic eep_en,
  input wire logic eep_valid,
  input wire logic [9:0] eep_div,
  input wire logic eep_dbl,
  input wire logic [VC_W-1:0] vctrl,
  output logic [9:0] loop_div,
  output logic loop_dbl,
  output logic gpio_status
);

  initial
  begin
    if (FMEM_DEPTH != 4)
    begin
      $error("sal_system_analog_loop_ctrl: frequency store must hold four words");
    end
  end

  // Divider legality check used by boot and bus paths
  function automatic logic div_ok(input logic [9:0] d);
    div_ok = (d >= `SAL_DIV_MIN) && (d <= `SAL_DIV_MAX);
  endfunction : div_ok

  sal_boot_e boot_r;
  sal_src_e src_r;
  logic [9:0] div_r;
  logic dbl_r;
  logic lol_r;
  logic gpio_en_r;
  logic chg_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic locked;
  logic req;
  logic wr;
  logic rd;
  logic [31:0] fmem_rd;
  logic frd_r;
  logic [1:0] fidx_nxt;
  logic fmem_we;
  sal_num_t freq_num;
  sal_den_t freq_den;

  // Request seen on the first cycle only; ack_r stops a second take
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = req && wb_we_i;
  assign rd = req && !wb_we_i;

  // Boot sequence: OTP wins over EEPROM, else defaults stay
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      boot_r <= SAL_BOOT_IDLE;
    end
    else
    begin
      case (boot_r)
        SAL_BOOT_IDLE:
        begin
          if (otp_en && otp_valid && div_ok(otp_div))
          begin
            boot_r <= SAL_BOOT_OTP; // RULE5
          end
          else if (eep_en && eep_valid && div_ok(eep_div))
          begin
            boot_r <= SAL_BOOT_EEP; // RULE5
          end
          else
          begin
            boot_r <= SAL_BOOT_DFLT; // RULE9
          end
        end
        SAL_BOOT_OTP: boot_r <= SAL_BOOT_DONE;
        SAL_BOOT_EEP: boot_r <= SAL_BOOT_DONE;
        SAL_BOOT_DFLT: boot_r <= SAL_BOOT_DONE;
        default: boot_r <= SAL_BOOT_DONE;
      endcase
    end
  end

  // Loop setting: boot load, then software writes once boot is done
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      div_r <= `SAL_DIV_RST; // RULE9
      dbl_r <= `SAL_DBL_RST; // RULE9
      src_r <= SAL_SRC_DFLT;
      chg_r <= 1'b0;
    end
    else
    begin
      chg_r <= 1'b0;
      if (boot_r == SAL_BOOT_OTP)
      begin
        div_r <= otp_div; // RULE5
        dbl_r <= otp_dbl; // RULE5
        src_r <= SAL_SRC_OTP;
        chg_r <= 1'b1;
      end
      else if (boot_r == SAL_BOOT_EEP)
      begin
        div_r <= eep_div; // RULE5
        dbl_r <= eep_dbl; // RULE5
        src_r <= SAL_SRC_EEP;
        chg_r <= 1'b1;
      end
      else if (boot_r == SAL_BOOT_DONE && wr && wb_adr_i == `SAL_OFF_CFG) // RULE6
      begin
        // Out-of-range divider is dropped whole so the loop never sees it
        if (wb_sel_i[1:0] == 2'b11 && div_ok(wb_dat_i[`SAL_CFG_DIV_MSB:`SAL_CFG_DIV_LSB]))
        begin
          div_r <= wb_dat_i[`SAL_CFG_DIV_MSB:`SAL_CFG_DIV_LSB]; // RULE3
          src_r <= SAL_SRC_SW;
          chg_r <= 1'b1;
        end
        if (wb_sel_i[2])
        begin
          dbl_r <= wb_dat_i[`SAL_CFG_DBL_BIT]; // RULE2
          src_r <= SAL_SRC_SW;
          chg_r <= 1'b1;
        end
      end
    end
  end

  // Alarm routing enable for the status pin
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      gpio_en_r <= 1'b0;
    end
    else if (wr && wb_adr_i == `SAL_OFF_GPIO && wb_sel_i[0])
    begin
      gpio_en_r <= wb_dat_i[0]; // RULE8
    end
  end

  // Alarm is live while lock is absent once boot has settled
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      lol_r <= 1'b0;
      gpio_status <= 1'b0;
    end
    else
    begin
      lol_r <= (boot_r == SAL_BOOT_DONE) && !locked; // RULE8
      gpio_status <= gpio_en_r && (boot_r == SAL_BOOT_DONE) && !locked; // RULE8
    end
  end

  // Outputs to the analog loop follow the registers
  assign loop_div = div_r;
  assign loop_dbl = dbl_r;

  sal_lock_det #(
    .VC_W(VC_W),
    .QUAL(`SAL_LOCK_QUAL_CYC)
  ) u_lock (
    .clock(clock),
    .rst_n(rst_n),
    .vctrl(vctrl),
    .div(div_r),
    .dbl(dbl_r),
    .cfg_chg(chg_r),
    .locked(locked)
  );

  // Frequency word index: lo/hi halves of numerator and denominator
  always_comb
  begin
    fidx_nxt = 2'b00;
    if (wb_adr_i == `SAL_OFF_FREQ_HI)
    begin
      fidx_nxt = 2'b01;
    end
  end
  assign fmem_we = wr && (wb_adr_i == `SAL_OFF_FREQ_LO || wb_adr_i == `SAL_OFF_FREQ_HI) && wb_sel_i == 4'hf;

  // Word 0 numerator bits 31:0, word 1 holds numerator 47:32 and denominator
  sal_freq_mem #(
    .DEPTH(FMEM_DEPTH),
    .WIDTH(32)
  ) u_fmem (
    .clock(clock),
    .we(fmem_we),
    .waddr(fidx_nxt),
    .wdata(wb_dat_i),
    .raddr(fidx_nxt),
    .rdata(fmem_rd)
  );

  // Read port follows the live address so the word is ready at ack; this flop picks it
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      frd_r <= 1'b0;
    end
    else if (rd)
    begin
      frd_r <= (wb_adr_i == `SAL_OFF_FREQ_LO) || (wb_adr_i == `SAL_OFF_FREQ_HI);
    end
  end

  // Ratio view kept for the frequency math
  assign freq_num = {16'h0000, fmem_rd}; // RULE1
  assign freq_den = fmem_rd[31:16]; // RULE1

  // Read data and single-cycle ack; unmapped reads give zero, writes ignored
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= req;
      if (rd)
      begin
        if (wb_adr_i == `SAL_OFF_CFG)
        begin
          dat_r <= {15'h0000, dbl_r, 6'h00, div_r};
        end
        else if (wb_adr_i == `SAL_OFF_STAT)
        begin
          dat_r <= {26'h0000000, src_r, 1'b0, boot_r == SAL_BOOT_DONE, lol_r, locked}; // RULE8
        end
        else if (wb_adr_i == `SAL_OFF_GPIO)
        begin
          dat_r <= {31'h00000000, gpio_en_r};
        end
        else if (wb_adr_i == `SAL_OFF_NVM)
        begin
          dat_r <= {28'h0000000, eep_valid, eep_en, otp_valid, otp_en};
        end
        else
        begin
          dat_r <= 32'h0000_0000;
        end
      end
    end
  end

  // Frequency words take the memory's registered output; select is a flop, not the live address
  assign wb_dat_o = frd_r ? fmem_rd : dat_r;
  assign wb_ack_o = ack_r;

  AST_DIV_RANGE: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
    (boot_r == SAL_BOOT_DONE && src_r != SAL_SRC_DFLT) |-> div_ok(div_r))
    else $error("divider outside legal range");
  AST_BAD_DIV_KEPT: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
    (boot_r == SAL_BOOT_DONE && wr && wb_adr_i == `SAL_OFF_CFG && !div_ok(wb_dat_i[9:0])) |=> $stable(div_r))
    else $error("illegal divider accepted");
  AST_DBL_WRITE: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
    (boot_r == SAL_BOOT_DONE && wr && wb_adr_i == `SAL_OFF_CFG && wb_sel_i[2])
      |=> dbl_r == $past(wb_dat_i[16]))
    else $error("doubler select not written");
  AST_OTP_LOAD: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    (boot_r == SAL_BOOT_IDLE && otp_en && otp_valid && div_ok(otp_div))
      |=> ##1 (div_r == $past(otp_div, 2) && src_r == SAL_SRC_OTP))
    else $error("OTP setting not loaded");
  AST_EEP_LOAD: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
    (boot_r == SAL_BOOT_IDLE && !(otp_en && otp_valid && div_ok(otp_div)) && eep_en && eep_valid
      && div_ok(eep_div)) |=> ##1 src_r == SAL_SRC_EEP)
    else $error("EEPROM setting not loaded");
  AST_DFLT_KEEP: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
    (boot_r == SAL_BOOT_DFLT) |=> (div_r == `SAL_DIV_RST && src_r == SAL_SRC_DFLT))
    else $error("defaults not kept");
  AST_SW_WRITE: assert property (@(posedge clock) disable iff (!rst_n) // RULE6
    (boot_r == SAL_BOOT_DONE && wr && wb_adr_i == `SAL_OFF_CFG && wb_sel_i[1:0] == 2'b11
      && div_ok(wb_dat_i[9:0])) |=> (div_r == $past(wb_dat_i[9:0]) && src_r == SAL_SRC_SW))
    else $error("software rewrite lost");
  AST_LOL_PIN: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
    (gpio_en_r && boot_r == SAL_BOOT_DONE && !locked) |=> gpio_status && lol_r)
    else $error("alarm not on status pin");
  AST_ACK_ONE: assert property (@(posedge clock) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  COV_OTP: cover property (@(posedge clock) boot_r == SAL_BOOT_OTP);
  COV_EEP: cover property (@(posedge clock) boot_r == SAL_BOOT_EEP);
  COV_LOCK: cover property (@(posedge clock) locked ##1 !locked);
  COV_SW: cover property (@(posedge clock) src_r == SAL_SRC_SW);

endmodule : sal_system_analog_loop_ctrl
